// >>> src/dca_defines.vh
// Constants for the DRAM channel arbitration/timing control slice.
// Assumes inclusion by bare name from the design files.
`ifndef DCA_DEFINES_VH
`define DCA_DEFINES_VH

// ==================================================
// Register byte offsets
`define DCA_OFS_CTRL     12'h000
`define DCA_OFS_SETUP    12'h004
`define DCA_OFS_TURN_LO  12'h008
`define DCA_OFS_MODE     12'h00C
`define DCA_OFS_STATUS   12'h010

// ==================================================
// Control register fields
`define DCA_EARLY_ARB_BIT   19
`define DCA_RXEN_TRAIN_BIT  18
`define DCA_SETUP_SYNC_BIT  15
`define DCA_RD2RD_HI_MSB    13
`define DCA_RD2RD_HI_LSB    12
`define DCA_WR2WR_HI_MSB    11
`define DCA_WR2WR_HI_LSB    10
`define DCA_CTRL_WMASK      32'h000C_BC00
`define DCA_CTRL_RESET      32'h0000_0000

// ==================================================
// Coarse setup register fields (each 6 bits)
`define DCA_SETUP_W         6
`define DCA_ADDR_CMD_LSB    0
`define DCA_CS_TERM_LSB     8
`define DCA_CKE_LSB         16
`define DCA_SETUP_WMASK     32'h003F_3F3F
`define DCA_SETUP_RESET     32'h0000_0000

// ==================================================
// Lower turnaround and mode fields
`define DCA_RD2RD_LO_LSB    0
`define DCA_WR2WR_LO_LSB    2
`define DCA_TURN_LO_RESET   4'h0
`define DCA_MODE_RESET      2'h0
`define DCA_DDR3_BIT        0
`define DCA_GANGED_BIT      1

// ==================================================
// Arbitration phase counts (controller clocks)
`define DCA_ARB_NORMAL      2'h2
`define DCA_ARB_SHORT       2'h1

`endif

// >>> src/dca_ctl.v
// APB register slice and derived controls for one DRAM channel controller.
// Assumes an APB master on pclk; command stream inputs synchronous to pclk.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "dca_defines.vh"

module dca_ctl #(
   parameter REV_C_OR_LATER = 1
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        cmd_valid,
   input  wire        cmd_is_read,
   output reg  [1:0]  arb_phase_cycles,
   output reg         rxen_training,
   output reg         clock_phase_align,
   output reg  [5:0]  addr_cmd_setup_eff,
   output reg  [5:0]  cs_termination_setup_eff,
   output reg  [5:0]  clock_enable_setup_eff,
   output reg  [3:0]  read_to_read_turnaround,
   output reg  [3:0]  write_to_write_turnaround
);

   // ==================================================
   // Register storage
   reg  [31:0] ctrl_reg;
   reg  [31:0] setup_reg;
   reg  [3:0]  turn_lo_reg;
   reg  [1:0]  mode_reg;
   reg         last_read_reg;
   reg  [31:0] ctrl_next;
   reg  [31:0] setup_next;
   reg  [3:0]  turn_lo_next;
   reg  [1:0]  mode_next;
   reg         last_read_next;

   // ==================================================
   // Output next values, registered below so every output is a flop
   reg  [31:0] prdata_next;
   reg         pready_next;
   reg         pslverr_next;
   reg  [1:0]  arb_next;
   reg         rxen_next;
   reg         align_next;
   reg  [5:0]  addr_cmd_next;
   reg  [5:0]  cs_term_next;
   reg  [5:0]  cke_next;
   reg  [3:0]  rd2rd_next;
   reg  [3:0]  wr2wr_next;

   // ==================================================
   // Decoded fields
   wire        setup_ph  = psel & ~penable;
   wire        wr_commit = psel & penable & pready & pwrite & ~pslverr;
   wire        early_en  = ctrl_reg[`DCA_EARLY_ARB_BIT];
   wire        train_en  = ctrl_reg[`DCA_RXEN_TRAIN_BIT];
   wire        sync_en   = ctrl_reg[`DCA_SETUP_SYNC_BIT];
   wire        ddr3_select = mode_reg[`DCA_DDR3_BIT];
   wire [5:0]  addr_cmd_coarse_setup = setup_reg[`DCA_ADDR_CMD_LSB +: `DCA_SETUP_W];
   wire [5:0]  cs_termination_coarse_setup = setup_reg[`DCA_CS_TERM_LSB +: `DCA_SETUP_W];
   wire [5:0]  clock_enable_coarse_setup = setup_reg[`DCA_CKE_LSB +: `DCA_SETUP_W];
   wire [1:0]  rd2rd_lo = turn_lo_reg[`DCA_RD2RD_LO_LSB +: 2];
   wire [1:0]  wr2wr_lo = turn_lo_reg[`DCA_WR2WR_LO_LSB +: 2];
   wire [1:0]  rd2rd_hi = ctrl_reg[`DCA_RD2RD_HI_MSB:`DCA_RD2RD_HI_LSB];
   wire [1:0]  wr2wr_hi = ctrl_reg[`DCA_WR2WR_HI_MSB:`DCA_WR2WR_HI_LSB];

   reg         addr_ok;
   reg  [31:0] rd_mux;

   // ==================================================
   // Read decode
   always @* begin
      addr_ok = 1'b1;
      rd_mux  = 32'h0000_0000;
      case (paddr)
         `DCA_OFS_CTRL:    rd_mux = ctrl_reg;
         `DCA_OFS_SETUP:   rd_mux = setup_reg;
         `DCA_OFS_TURN_LO: rd_mux = {28'h000_0000, turn_lo_reg};
         `DCA_OFS_MODE:    rd_mux = {30'h0000_0000, mode_reg};
         `DCA_OFS_STATUS:  rd_mux = {20'h0_0000, read_to_read_turnaround,
                                     write_to_write_turnaround, rxen_training,
                                     clock_phase_align, arb_phase_cycles};
         default:          addr_ok = 1'b0;
      endcase
   end

   // ==================================================
   // APB slave: one access cycle, answer prepared in the setup cycle
   // Read data latched at setup, so it stands through the access phase
   // No wait states: ready always follows the setup cycle by one
   always @* begin
      pready_next  = setup_ph;
      pslverr_next = setup_ph & ~addr_ok;
      prdata_next  = prdata;
      if (setup_ph && !pwrite) begin
         prdata_next = rd_mux;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= prdata_next;
         pready  <= pready_next;
         pslverr <= pslverr_next;
      end
   end

   // ==================================================
   // Register writes
   // Only a completed, accepted access writes; a refused one is dropped
   always @* begin
      ctrl_next    = ctrl_reg;
      setup_next   = setup_reg;
      turn_lo_next = turn_lo_reg;
      mode_next    = mode_reg;
      if (wr_commit) begin
         case (paddr)
            `DCA_OFS_CTRL:    ctrl_next = pwdata & `DCA_CTRL_WMASK;
            `DCA_OFS_SETUP:   setup_next = pwdata & `DCA_SETUP_WMASK;
            `DCA_OFS_TURN_LO: turn_lo_next = pwdata[3:0];
            `DCA_OFS_MODE:    mode_next = pwdata[1:0];
            default:          mode_next = mode_reg;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg    <= `DCA_CTRL_RESET;
         setup_reg   <= `DCA_SETUP_RESET;
         turn_lo_reg <= `DCA_TURN_LO_RESET;
         mode_reg    <= `DCA_MODE_RESET;
      end else begin
         ctrl_reg    <= ctrl_next;
         setup_reg   <= setup_next;
         turn_lo_reg <= turn_lo_next;
         mode_reg    <= mode_next;
      end
   end

   // ==================================================
   // Arbitration phase length per command
   // Rev B only gains on a read that follows a read; later parts on all.
   // Holds its value between commands
   always @* begin
      last_read_next = last_read_reg;
      arb_next       = arb_phase_cycles;
      if (cmd_valid) begin
         last_read_next = cmd_is_read;
         if (early_en && REV_C_OR_LATER != 0) begin
            arb_next = `DCA_ARB_SHORT;
         end else if (early_en && cmd_is_read && last_read_reg) begin
            arb_next = `DCA_ARB_SHORT;
         end else begin
            arb_next = `DCA_ARB_NORMAL;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_read_reg    <= 1'b0;
         arb_phase_cycles <= `DCA_ARB_NORMAL;
      end else begin
         last_read_reg    <= last_read_next;
         arb_phase_cycles <= arb_next;
      end
   end

   // ==================================================
   // Training, setup alignment and turnaround outputs
   always @* begin
      rxen_next  = train_en;
      align_next = sync_en;
      // Aligned clocks make coarse setups meaningless, so zero them
      if (sync_en) begin
         addr_cmd_next = 6'h00;
         cs_term_next  = 6'h00;
         cke_next      = 6'h00;
      end else begin
         addr_cmd_next = addr_cmd_coarse_setup;
         cs_term_next  = cs_termination_coarse_setup;
         cke_next      = clock_enable_coarse_setup;
      end
      // Upper turnaround bits only count in DDR3 mode
      if (ddr3_select) begin
         rd2rd_next = {rd2rd_hi, rd2rd_lo};
         wr2wr_next = {wr2wr_hi, wr2wr_lo};
      end else begin
         rd2rd_next = {2'h0, rd2rd_lo};
         wr2wr_next = {2'h0, wr2wr_lo};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxen_training             <= 1'b0;
         clock_phase_align         <= 1'b0;
         addr_cmd_setup_eff        <= 6'h00;
         cs_termination_setup_eff  <= 6'h00;
         clock_enable_setup_eff    <= 6'h00;
         read_to_read_turnaround   <= 4'h0;
         write_to_write_turnaround <= 4'h0;
      end else begin
         rxen_training             <= rxen_next;
         clock_phase_align         <= align_next;
         addr_cmd_setup_eff        <= addr_cmd_next;
         cs_termination_setup_eff  <= cs_term_next;
         clock_enable_setup_eff    <= cke_next;
         read_to_read_turnaround   <= rd2rd_next;
         write_to_write_turnaround <= wr2wr_next;
      end
   end

endmodule

// >>> verif/dca_ctl_props.sv
// Checker for the control slice, bound to the dca_ctl ports.
// Assumes one clock pclk and async active-low presetn.
`timescale 1ns/100ps
module dca_ctl_props (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire        pready,
   input wire        pslverr,
   input wire        cmd_valid,
   input wire [31:0] prdata,
   input wire [1:0]  arb_phase_cycles,
   input wire        rxen_training,
   input wire        clock_phase_align,
   input wire [5:0]  addr_cmd_setup_eff,
   input wire [5:0]  cs_termination_setup_eff,
   input wire [5:0]  clock_enable_setup_eff,
   input wire [3:0]  read_to_read_turnaround,
   input wire [3:0]  write_to_write_turnaround
);
   // ==================================================
   // Properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   wire done = psel && penable && pready && pwrite;
   property p_ans; s_setup |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("no answer after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready held too long");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_rdz; pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
   a_rdz: assert property (p_rdz) else $error("refused read not zero");
   property p_sync; clock_phase_align |-> {addr_cmd_setup_eff, cs_termination_setup_eff,
      clock_enable_setup_eff} == 18'h0_0000; endproperty
   a_sync: assert property (p_sync) else $error("setup used while aligned");
   property p_arb; arb_phase_cycles == 2'h1 || arb_phase_cycles == 2'h2; endproperty
   a_arb: assert property (p_arb) else $error("bad phase count");
   property p_arbh; $changed(arb_phase_cycles) |-> $past(cmd_valid); endproperty
   a_arbh: assert property (p_arbh) else $error("phase moved without cmd");
   // Register written at the commit edge, output one edge later
   property p_rxen; $changed(rxen_training) |-> $past(done, 2); endproperty
   a_rxen: assert property (p_rxen) else $error("training moved alone");
   property p_turn; $changed({read_to_read_turnaround, write_to_write_turnaround})
      |-> $past(done, 2); endproperty
   a_turn: assert property (p_turn) else $error("turnaround moved alone");
endmodule

// >>> verif/dca_cmd_src.sv
// Command stream model standing for the DRAM side traffic.
// Assumes the bench calls issue from one process only.
`timescale 1ns/100ps
module dca_cmd_src (
   input  wire pclk,
   output reg  cmd_valid,
   output reg  cmd_is_read
);
   initial begin
      cmd_valid = 1'b0;
      cmd_is_read = 1'b0;
   end
   // Read flag inverted when idle so no stale value looks valid
   task issue(input r);
      begin
         @(posedge pclk);
         cmd_valid <= 1'b1;
         cmd_is_read <= r;
         @(posedge pclk);
         cmd_valid <= 1'b0;
         cmd_is_read <= ~r;
      end
   endtask
endmodule

// >>> verif/tb_top.sv
// Bench: APB master tasks and the command model around dca_ctl.
// Assumes pclk at 20 MHz and a 6-cycle reset at start.
`timescale 1ns/100ps
`include "dca_defines.vh"
module tb_top;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0000_0000, q;
   wire [31:0] prdata;
   wire pready, pslverr, cmd_valid, cmd_is_read, rxen, align;
   wire [1:0] arb, arb_b;
   wire [5:0] ac, cs, ck;
   wire [3:0] rr, ww;
   integer n_errors = 0, checked = 0, cyc = 0;
   always #25 pclk = ~pclk;
   dca_ctl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read),
      .arb_phase_cycles(arb), .rxen_training(rxen), .clock_phase_align(align),
      .addr_cmd_setup_eff(ac), .cs_termination_setup_eff(cs), .clock_enable_setup_eff(ck),
      .read_to_read_turnaround(rr), .write_to_write_turnaround(ww));
   // Second copy as an early revision part, sharing the bus and commands
   dca_ctl #(.REV_C_OR_LATER(0)) uut_b (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
      .pready(), .pslverr(), .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read),
      .arb_phase_cycles(arb_b), .rxen_training(), .clock_phase_align(),
      .addr_cmd_setup_eff(), .cs_termination_setup_eff(), .clock_enable_setup_eff(),
      .read_to_read_turnaround(), .write_to_write_turnaround());
   dca_cmd_src u_src (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read));
   task final_report;
      begin
         $display("checked %0d n_errors %0d", checked, n_errors);
         if (n_errors == 0 && checked > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // ==================================================
   // APB master: request held until pready seen at an edge
   task apb(input [11:0] a, input w, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do @(posedge pclk); while (pready !== 1'b1);
         q = prdata;
         chk("slverr", a > 12'h010, pslverr);
         psel <= 1'b0; penable <= 1'b0;
         repeat (2) @(negedge pclk);
      end
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors = n_errors + 1;
         final_report;
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(`DCA_OFS_CTRL, 0, 0); chk("ctrl0", 32'h0000_0000, q);
      apb(`DCA_OFS_CTRL, 1, 32'hFFFF_FFFF);
      apb(`DCA_OFS_CTRL, 0, 0); chk("ctrlrw", 32'h000C_BC00, q);
      chk("train", 2'h3, {rxen, align});
      apb(`DCA_OFS_SETUP, 1, 32'h003F_2A15);
      chk("sync", 18'h0_0000, {ac, cs, ck});
      apb(`DCA_OFS_SETUP, 0, 0); chk("setup", 32'h003F_2A15, q);
      apb(`DCA_OFS_MODE, 1, 32'h0000_0003);
      apb(`DCA_OFS_TURN_LO, 1, 32'h0000_0009);
      chk("turn", 8'hDE, {rr, ww});
      u_src.issue(1'b1); @(negedge pclk); chk("early", 2'h1, arb);
      chk("revb1", 2'h2, arb_b);
      u_src.issue(1'b1); @(negedge pclk); chk("revb2", 2'h1, arb_b);
      u_src.issue(1'b0); @(negedge pclk); chk("revbw", 2'h2, arb_b);
      chk("earlyw", 2'h1, arb);
      apb(`DCA_OFS_CTRL, 1, 0);
      chk("own", {6'h15, 6'h2A, 6'h3F}, {ac, cs, ck});
      chk("lo", 10'h012, {rxen, align, rr, ww});
      u_src.issue(1'b0); @(negedge pclk); chk("norm", 2'h2, arb);
      u_src.issue(1'b1); u_src.issue(1'b1);
      @(negedge pclk); chk("normb", 2'h2, arb_b);
      apb(`DCA_OFS_STATUS, 0, 0); chk("status", 32'h0000_0122, q);
      apb(12'h100, 0, 0); chk("unmap", 32'h0000_0000, q);
      final_report;
   end
endmodule
bind dca_ctl dca_ctl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
   .cmd_valid(cmd_valid), .prdata(prdata), .arb_phase_cycles(arb_phase_cycles),
   .rxen_training(rxen_training), .clock_phase_align(clock_phase_align),
   .addr_cmd_setup_eff(addr_cmd_setup_eff), .cs_termination_setup_eff(cs_termination_setup_eff),
   .clock_enable_setup_eff(clock_enable_setup_eff),
   .read_to_read_turnaround(read_to_read_turnaround),
   .write_to_write_turnaround(write_to_write_turnaround));
